/* File: pkg/ebr_pkg.sv */
// Package for the endian byte reorder block.
// Assumes a single processor clock and a 32-bit data path.
package ebr_pkg;
    // ==========================================================
    // Access sizes
    typedef enum logic [1:0] {
        EBR_SZ_BYTE,
        EBR_SZ_HALF,
        EBR_SZ_WORD,
        EBR_SZ_DWORD
    } ebr_size_t;

    // ==========================================================
    // Endian attribute values
    localparam logic EBR_E_BIG    = 1'b0;
    localparam logic EBR_E_LITTLE = 1'b1;

    // ==========================================================
    // Widths and reset values
    localparam int   EBR_REGION_W   = 32;
    localparam int   EBR_REGION_IDX = 27;  // Top five address bits
    localparam logic [31:0] EBR_WORD_RST = 32'h0000_0000;

    // ==========================================================
    // Alignment masks on address bits 28:31 (lsb four bits)
    localparam logic [3:0] EBR_MASK_BYTE  = 4'h0;
    localparam logic [3:0] EBR_MASK_HALF  = 4'h1;
    localparam logic [3:0] EBR_MASK_WORD  = 4'h3;
    localparam logic [3:0] EBR_MASK_DWORD = 4'h7;
endpackage : ebr_pkg

/* File: design/ebr_swap.sv */
// Combinational byte swapper for one 32-bit lane.
// Assumes the caller gives the size and whether to reverse.
`timescale 1ns/1ps
module ebr_swap (
    input  wire logic              rev,
    input  wire ebr_pkg::ebr_size_t size,
    input  wire logic [31:0]       din,
    output logic      [31:0]       dout
);
    import ebr_pkg::*;

    // ==========================================================
    // Reversal by size; bytes pass, doublewords reverse like words (word lanes)
    always_comb begin
        dout = din;
        if (rev) begin
            case (size)
                EBR_SZ_HALF: dout = {din[31:16], din[7:0], din[15:8]};
                EBR_SZ_WORD: dout = {din[7:0], din[15:8],
                                     din[23:16], din[31:24]};
                EBR_SZ_DWORD: dout = {din[7:0], din[15:8],
                                      din[23:16], din[31:24]};
                default: dout = din;
            endcase
        end
    end
endmodule : ebr_swap

/* File: design/ebr_top.sv */
// Endian steering, fetch reversal, data reversal and alignment check.
// Assumes the translation lookup supplies the entry's endian bit and
// that the caches sit on either side of the registered outputs.
// Behaviour
// - Every access carries endian attribute, 1=little
// - Translation on: attribute from translation entry
// - Translation off: attribute from mapping register (code: only when both translate enables are off)
// - Little-endian never changes the access address
// - Little fetches reversed before instruction cache
// - Instruction cache words always big-endian
// - Data cache unreordered; swap at registers
// - Byte keep, halfword swap, word swap
// - Little-endian adds no alignment exceptions
// - Big-endian alignment faults also apply little
// - Big-endian: high register byte, low address
// - Byte-reverse ops invert register/address mapping
// - Aligned only when address multiple of length
// - Low nibble patterns xxxx xxx0 xx00 x000
// - Instruction words aligned four-byte items
// - Bit 0 most significant; 28:31 low bits
`timescale 1ns/1ps
module ebr_top (
    input  wire logic                  ref_clk,
    input  wire logic                  resetn,
    // Translation and mapping state
    input  wire logic                  instr_translate_enable,
    input  wire logic                  data_translate_enable,
    input  wire logic [31:0]           storage_le_map_reg,
    // Instruction fetch path, memory to instruction cache
    input  wire logic                  fetch_valid,
    input  wire logic [31:0]           fetch_addr,
    input  wire logic                  fetch_tlb_e,
    input  wire logic [31:0]           fetch_mem_word,
    output logic                       icache_fill_valid,
    output logic      [31:0]           icache_fill_addr,
    output logic      [31:0]           icache_fill_word,
    output logic                       icache_fill_e,
    output logic                       fetch_misaligned,
    // Data path, data cache and general registers
    input  wire logic                  data_valid,
    input  wire logic                  data_is_store,
    input  wire logic                  data_byte_rev,
    input  wire ebr_pkg::ebr_size_t    data_size,
    input  wire logic [31:0]           data_addr,
    input  wire logic                  data_tlb_e,
    input  wire logic [31:0]           dcache_rdata,
    input  wire logic [31:0]           general_register_wdata,
    output logic                       data_done,
    output logic      [31:0]           data_mem_addr,
    output logic      [31:0]           general_register_rdata,
    output logic      [31:0]           dcache_wdata,
    output logic                       data_e,
    output logic                       data_misaligned
);
    import ebr_pkg::*;

    // ==========================================================
    // Functions
    // Region index from address; bit 0 is the msb
    function automatic logic region_le(input logic [31:0] addr,
                                       input logic [31:0] map);
        logic [4:0] idx;
        idx = addr[31:EBR_REGION_IDX];
        region_le = map[5'd31 - idx];
    endfunction : region_le

    // Natural alignment on the four low address bits
    function automatic logic is_misaligned(input logic [31:0] addr,
                                           input ebr_size_t sz);
        logic [3:0] m;
        case (sz)
            EBR_SZ_BYTE: m = EBR_MASK_BYTE;
            EBR_SZ_HALF: m = EBR_MASK_HALF;
            EBR_SZ_WORD: m = EBR_MASK_WORD;
            default:     m = EBR_MASK_DWORD;
        endcase
        is_misaligned = |(addr[3:0] & m);
    endfunction : is_misaligned

    // ==========================================================
    // Endian attribute selection
    logic virt_mode;
    logic fetch_e;
    logic dat_e;
    assign virt_mode = instr_translate_enable | data_translate_enable;
    // Virtual mode uses entry bit, real mode the map
    assign fetch_e = virt_mode ? fetch_tlb_e
                               : region_le(fetch_addr, storage_le_map_reg);
    assign dat_e   = virt_mode ? data_tlb_e
                               : region_le(data_addr, storage_le_map_reg);

    // ==========================================================
    // Fetch path reversal
    logic [31:0] fetch_swapped;
    ebr_swap u_fetch_swap (
        .rev  (fetch_e == EBR_E_LITTLE),
        .size (EBR_SZ_WORD),
        .din  (fetch_mem_word),
        .dout (fetch_swapped)
    );

    // Fill register: cache only ever sees big-endian words
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            icache_fill_valid <= 1'b0;
            icache_fill_addr  <= EBR_WORD_RST;
            icache_fill_word  <= EBR_WORD_RST;
            icache_fill_e     <= EBR_E_BIG;
            fetch_misaligned  <= 1'b0;
        end else begin
            icache_fill_valid <= fetch_valid;
            if (fetch_valid) begin
                icache_fill_addr <= fetch_addr;
                icache_fill_word <= fetch_swapped;
                icache_fill_e    <= fetch_e;
                fetch_misaligned <= is_misaligned(fetch_addr,
                                                  EBR_SZ_WORD);
            end
        end
    end

    // ==========================================================
    // Data path reversal between data cache and registers
    logic data_rev;
    logic [31:0] load_swapped;
    logic [31:0] store_swapped;
    // Reverse bit XOR: byte-reverse ops flip the mapping
    assign data_rev = (dat_e == EBR_E_LITTLE) ^ data_byte_rev;

    ebr_swap u_load_swap (
        .rev  (data_rev),
        .size (data_size),
        .din  (dcache_rdata),
        .dout (load_swapped)
    );
    ebr_swap u_store_swap (
        .rev  (data_rev),
        .size (data_size),
        .din  (general_register_wdata),
        .dout (store_swapped)
    );

    // Data result register; cache side never reordered
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            data_done              <= 1'b0;
            data_mem_addr          <= EBR_WORD_RST;
            general_register_rdata <= EBR_WORD_RST;
            dcache_wdata           <= EBR_WORD_RST;
            data_e                 <= EBR_E_BIG;
        end else begin
            data_done <= data_valid;
            if (data_valid) begin
                data_mem_addr <= data_addr;
                data_e        <= dat_e;
                if (data_is_store)
                    dcache_wdata <= store_swapped;
                else
                    general_register_rdata <= load_swapped;
            end
        end
    end

    // Alignment ignores endianness entirely
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            data_misaligned <= 1'b0;
        end else if (data_valid) begin
            data_misaligned <= is_misaligned(data_addr, data_size);
        end
    end

    // ==========================================================
    // Assertions
    fill_be_order_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        fetch_valid && fetch_e |=> icache_fill_word ==
            {$past(fetch_mem_word[7:0]), $past(fetch_mem_word[15:8]),
             $past(fetch_mem_word[23:16]), $past(fetch_mem_word[31:24])})
        else $error("little fetch not reversed");
    fill_big_pass_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        fetch_valid && !fetch_e |=> icache_fill_word == $past(fetch_mem_word))
        else $error("big fetch altered");
    fetch_align_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        fetch_valid |=> fetch_misaligned == ($past(fetch_addr[1:0]) != 2'h0))
        else $error("fetch alignment wrong");
    addr_kept_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        data_valid |=> data_mem_addr == $past(data_addr))
        else $error("data address modified");
    real_mode_e_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        data_valid && !virt_mode |=> data_e ==
            $past(storage_le_map_reg[5'd31 - data_addr[31:27]]))
        else $error("real mode endian wrong");
    virt_mode_e_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        data_valid && virt_mode |=> data_e == $past(data_tlb_e))
        else $error("virtual mode endian wrong");
    byte_load_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        data_valid && !data_is_store && data_size == EBR_SZ_BYTE
        |=> general_register_rdata == $past(dcache_rdata))
        else $error("byte load reordered");
    half_load_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        data_valid && !data_is_store && data_size == EBR_SZ_HALF && data_rev
        |=> general_register_rdata[7:0] == $past(dcache_rdata[15:8]))
        else $error("halfword not swapped");
    word_load_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        data_valid && !data_is_store && data_size == EBR_SZ_WORD && data_rev
        |=> general_register_rdata ==
            {$past(dcache_rdata[7:0]), $past(dcache_rdata[15:8]),
             $past(dcache_rdata[23:16]), $past(dcache_rdata[31:24])})
        else $error("word load not reversed");
    load_kept_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        data_valid && !data_is_store && !data_rev
        |=> general_register_rdata == $past(dcache_rdata))
        else $error("unreversed load altered");
    store_half_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        data_valid && data_is_store && data_size == EBR_SZ_HALF && data_rev
        |=> dcache_wdata == {$past(general_register_wdata[31:16]),
            $past(general_register_wdata[7:0]),
            $past(general_register_wdata[15:8])})
        else $error("halfword store not swapped");
    align_same_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        data_valid && data_size == EBR_SZ_WORD
        |=> data_misaligned == ($past(data_addr[1:0]) != 2'b00))
        else $error("word alignment wrong");

    // Steps of one data access: taken, then answered for one cycle
    sequence data_take_s;
        data_valid;
    endsequence
    sequence data_answer_s;
        data_done ##1 (data_done == $past(data_valid));
    endsequence
    done_follow_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        data_take_s |=> data_answer_s)
        else $error("done not one cycle after valid");
endmodule : ebr_top

/* File: testbench/ebr_mem_model.sv */
// Memory and cache stand-in that answers word lookups for the bench.
// Assumes addresses settle after the bench drives them mid-cycle.
`timescale 1ns/1ps
module ebr_mem_model (
    input  wire logic [31:0] addr,
    input  wire logic [31:0] salt,
    output logic      [31:0] word
);
    // ==========================================================
    // Contents mix address and salt so every lookup differs
    assign word = {addr[31:16] ^ salt[15:0], addr[15:0] ^ salt[31:16]};
endmodule : ebr_mem_model

/* File: testbench/endian_byte_reorder_tb.sv */
// Self-checking bench for the byte reorder block, queue scoreboard.
// Assumes the memory stand-in feeds fetch words and data cache reads.
`timescale 1ns/1ps
module endian_byte_reorder_tb;
    import ebr_pkg::*;
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
    // ==========================================================
    // Signals
    logic ref_clk = 0, resetn = 0, instr_translate_enable = 0;
    logic data_translate_enable = 0, fetch_valid = 0, fetch_tlb_e = 0;
    logic [31:0] storage_le_map_reg = 0, fetch_addr = 0, data_addr = 0;
    logic data_valid = 0, data_is_store = 0, data_byte_rev = 0;
    logic data_tlb_e = 0, icache_fill_valid, icache_fill_e, data_e;
    logic fetch_misaligned, data_done, data_misaligned;
    logic [31:0] fetch_mem_word, dcache_rdata, general_register_wdata = 0;
    logic [31:0] icache_fill_addr, icache_fill_word, data_mem_addr;
    logic [31:0] general_register_rdata, dcache_wdata, salt = 0;
    ebr_size_t data_size = EBR_SZ_BYTE;
    logic [65:0] fq[$], fx;
    logic [66:0] dq[$], dx;
    int seed = 18, n_fail = 0, compares = 0;
    always #5 ref_clk = ~ref_clk;
    ebr_top uut (
        .ref_clk                (ref_clk),
        .resetn                 (resetn),
        .instr_translate_enable (instr_translate_enable),
        .data_translate_enable  (data_translate_enable),
        .storage_le_map_reg     (storage_le_map_reg),
        .fetch_valid            (fetch_valid),
        .fetch_addr             (fetch_addr),
        .fetch_tlb_e            (fetch_tlb_e),
        .fetch_mem_word         (fetch_mem_word),
        .icache_fill_valid      (icache_fill_valid),
        .icache_fill_addr       (icache_fill_addr),
        .icache_fill_word       (icache_fill_word),
        .icache_fill_e          (icache_fill_e),
        .fetch_misaligned       (fetch_misaligned),
        .data_valid             (data_valid),
        .data_is_store          (data_is_store),
        .data_byte_rev          (data_byte_rev),
        .data_size              (data_size),
        .data_addr              (data_addr),
        .data_tlb_e             (data_tlb_e),
        .dcache_rdata           (dcache_rdata),
        .general_register_wdata (general_register_wdata),
        .data_done              (data_done),
        .data_mem_addr          (data_mem_addr),
        .general_register_rdata (general_register_rdata),
        .dcache_wdata           (dcache_wdata),
        .data_e                 (data_e),
        .data_misaligned        (data_misaligned)
    );
    ebr_mem_model fmem (.addr(fetch_addr), .salt(salt),
                        .word(fetch_mem_word));
    ebr_mem_model dmem (.addr(data_addr), .salt(~salt),
                        .word(dcache_rdata));
    // ==========================================================
    // Reference helpers
    function automatic logic pick_e(logic [31:0] a, logic t);
        return (instr_translate_enable | data_translate_enable) ? t
            : storage_le_map_reg[5'd31 - a[31:27]];
    endfunction : pick_e
    function automatic logic [31:0] sw(logic r, ebr_size_t s,
                                       logic [31:0] d);
        if (!r || s == EBR_SZ_BYTE) return d;
        if (s == EBR_SZ_HALF) return {d[31:16], d[7:0], d[15:8]};
        return {d[7:0], d[15:8], d[23:16], d[31:24]};
    endfunction : sw
    function automatic logic [3:0] msk(ebr_size_t s);
        case (s)
            EBR_SZ_BYTE: return EBR_MASK_BYTE;
            EBR_SZ_HALF: return EBR_MASK_HALF;
            EBR_SZ_WORD: return EBR_MASK_WORD;
            default:     return EBR_MASK_DWORD;
        endcase
    endfunction : msk
    // ==========================================================
    // Verdict
    task automatic tally_and_finish;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    // ==========================================================
    // Every output at its reset value
    task automatic check_idle;
        `CHK({icache_fill_valid, icache_fill_e}, 2'h0)
        `CHK({data_done, data_e}, 2'h0)
        `CHK({fetch_misaligned, data_misaligned}, 2'h0)
        `CHK(icache_fill_addr | data_mem_addr, EBR_WORD_RST)
        `CHK(icache_fill_word, EBR_WORD_RST)
        `CHK(general_register_rdata | dcache_wdata, EBR_WORD_RST)
    endtask : check_idle
    // ==========================================================
    // One cycle of stimulus with expected results noted
    task automatic drive(input logic fv, input logic dv);
        logic        fe, de;
        logic [31:0] r, dd;
        @(negedge ref_clk);
        r = $random(seed);
        fetch_valid = fv;
        data_valid = dv;
        fetch_addr = $random(seed);
        data_addr = $random(seed);
        salt = $random(seed);
        general_register_wdata = $random(seed);
        {fetch_tlb_e, data_tlb_e, data_is_store, data_byte_rev} = r[5:2];
        data_size = ebr_size_t'(r[1:0]);
        #1;
        fe = pick_e(fetch_addr, fetch_tlb_e);
        de = pick_e(data_addr, data_tlb_e);
        dd = data_is_store ? general_register_wdata : dcache_rdata;
        if (fv) fq.push_back({fetch_addr, sw(fe, EBR_SZ_WORD,
            fetch_mem_word), fe, fetch_addr[1:0] != 2'h0});
        if (dv) dq.push_back({data_is_store, data_addr,
            sw(de ^ data_byte_rev, data_size, dd), de,
            |(data_addr[3:0] & msk(data_size))});
    endtask : drive
    // ==========================================================
    // Watcher takes the oldest note when a result appears
    always @(posedge ref_clk) begin
        #1;
        if (icache_fill_valid === 1'b1) begin
            `CHK(fq.size() > 0, 1'b1)
            fx = fq.pop_front();
            `CHK(icache_fill_addr, fx[65:34])
            `CHK(icache_fill_word, fx[33:2])
            `CHK(icache_fill_e, fx[1])
            `CHK(fetch_misaligned, fx[0])
        end
        if (data_done === 1'b1) begin
            `CHK(dq.size() > 0, 1'b1)
            dx = dq.pop_front();
            `CHK(data_mem_addr, dx[65:34])
            `CHK(data_e, dx[1])
            `CHK(data_misaligned, dx[0])
            if (dx[66]) `CHK(dcache_wdata, dx[33:2])
            else `CHK(general_register_rdata, dx[33:2])
        end
    end
    // ==========================================================
    // Watchdog
    initial begin
        #200000;
        n_fail++;
        tally_and_finish();
    end
    // ==========================================================
    // Main sequence: every translate mode, random back-to-back traffic
    initial begin
        int m, i;
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk);
        check_idle();
        resetn = 1;
        @(negedge ref_clk);
        check_idle();
        for (m = 0; m < 4; m++) begin
            {instr_translate_enable, data_translate_enable} = m[1:0];
            // Map changes only once the pipe has drained
            storage_le_map_reg = $random(seed);
            for (i = 0; i < 80; i++) drive(i % 7 != 3, i % 5 != 2);
            drive(0, 0);
            drive(0, 0);
            $display("test translate mode %0d done", m);
        end
        // Mid-run reset clears every output, then traffic resumes
        @(negedge ref_clk);
        resetn = 0;
        #1;
        check_idle();
        @(negedge ref_clk);
        resetn = 1;
        for (i = 0; i < 20; i++) drive(i % 3 != 0, i % 2 == 0);
        drive(0, 0);
        drive(0, 0);
        $display("test mid-run reset done");
        `CHK(fq.size() + dq.size(), 0)
        tally_and_finish();
    end
endmodule : endian_byte_reorder_tb
